// [src/srbg_top.sv]
// Design decisions made here: register access over APB and the register addresses.
module srbg_top
  import srbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic receive_pin,
  input wire logic receive_idle_flag,
  input wire logic autobaud_overflow_flag,
  input wire logic autobaud_done,
  input wire logic transmit_shift_empty,
  input wire logic receive_flag_clear,
  output logic baud_tick,
  output logic [15:0] divisor_value,
  output logic sync_mode,
  output logic high_speed_select,
  output logic wide_divider_select,
  output logic clock_polarity_select,
  output logic wake_on_edge_enable,
  output logic autobaud_active,
  output logic receive_interrupt_flag,
  output logic [7:0] transmit_control,
  output logic [7:0] receive_control
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] divisor_low_reg;
  logic [7:0] divisor_high_reg;
  logic [7:0] transmit_control_reg;
  logic [7:0] receive_control_reg;
  logic polarity_reg;
  logic wide_reg;
  logic wake_reg;
  logic wake_next;
  logic autobaud_reg;
  logic autobaud_next;
  logic rx_flag_reg;
  logic rx_flag_next;
  logic [31:0] prdata_reg;

  // receive pin synchroniser
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_prev_reg;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic setup_phase;
  logic write_access;
  logic hit_baud;
  logic hit_transmit;
  logic hit_receive;
  logic hit_low;
  logic hit_high;
  logic hit_any;
  logic wr_baud;
  logic wr_transmit;
  logic wr_receive;
  logic wr_low;
  logic wr_high;
  logic divisor_written;
  logic [7:0] wbyte;
  logic [7:0] baud_control_view;
  logic [7:0] transmit_control_view;
  logic [7:0] read_byte;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign write_access = psel && penable && pwrite;
  assign wbyte = pwdata[7:0];

  assign hit_baud = (paddr == OFF_BAUD_CONTROL);
  assign hit_transmit = (paddr == OFF_TRANSMIT_CONTROL);
  assign hit_receive = (paddr == OFF_RECEIVE_CONTROL);
  assign hit_low = (paddr == OFF_DIVISOR_LOW);
  assign hit_high = (paddr == OFF_DIVISOR_HIGH);
  assign hit_any = hit_baud || hit_transmit || hit_receive || hit_low || hit_high;

  // unmapped addresses answer with an error and change nothing
  assign pslverr = psel && penable && !hit_any;

  assign wr_baud = write_access && hit_baud;
  assign wr_transmit = write_access && hit_transmit;
  assign wr_receive = write_access && hit_receive;
  assign wr_low = write_access && hit_low;
  assign wr_high = write_access && hit_high;
  assign divisor_written = wr_low || wr_high;

  // ----------------------------------------
  // read views
  // ----------------------------------------
  // unimplemented bits 5 and 2 read as zero
  always_comb begin
    baud_control_view = BYTE_RESET;
    baud_control_view[BC_AUTOBAUD_OVF_BIT] = autobaud_overflow_flag;
    baud_control_view[BC_RX_IDLE_BIT] = receive_idle_flag;
    baud_control_view[BC_POLARITY_BIT] = polarity_reg;
    baud_control_view[BC_WIDE_BIT] = wide_reg;
    baud_control_view[BC_WAKE_BIT] = wake_reg;
    baud_control_view[BC_AUTOBAUD_BIT] = autobaud_reg;
  end

  // shift-empty is live status, not stored
  always_comb begin
    transmit_control_view = transmit_control_reg;
    transmit_control_view[TC_SHIFT_EMPTY_BIT] = transmit_shift_empty;
  end

  always_comb begin
    read_byte = BYTE_RESET;
    if (hit_baud) begin
      read_byte = baud_control_view;
    end else if (hit_transmit) begin
      read_byte = transmit_control_view;
    end else if (hit_receive) begin
      read_byte = receive_control_reg;
    end else if (hit_low) begin
      read_byte = divisor_low_reg;
    end else if (hit_high) begin
      read_byte = divisor_high_reg;
    end
  end

  // read data captured in setup, stable through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      prdata_reg <= {UPPER_ZERO, read_byte};
    end
  end

  assign prdata = prdata_reg;

  // ----------------------------------------
  // divisor and control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_low_reg <= DIVISOR_RESET;
    end else if (wr_low) begin
      divisor_low_reg <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_high_reg <= DIVISOR_RESET;
    end else if (wr_high) begin
      divisor_high_reg <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_control_reg <= BYTE_RESET;
    end else if (wr_transmit) begin
      transmit_control_reg <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_control_reg <= BYTE_RESET;
    end else if (wr_receive) begin
      receive_control_reg <= wbyte;
    end
  end

  // width reset to 8-bit; only software changes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity_reg <= 1'b0;
      wide_reg <= 1'b0;
    end else if (wr_baud) begin
      polarity_reg <= wbyte[BC_POLARITY_BIT];
      wide_reg <= wbyte[BC_WIDE_BIT];
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic sync_bit;
  logic high_speed_bit;
  logic [6:0] factor;
  logic prescale_step;

  assign sync_bit = transmit_control_reg[TC_SYNC_BIT];
  assign high_speed_bit = transmit_control_reg[TC_HIGH_SPEED_BIT];
  assign factor = srbg_factor(sync_bit, wide_reg, high_speed_bit);
  assign divisor_value = {divisor_high_reg, divisor_low_reg};

  // ----------------------------------------
  // baud rate timer
  // ----------------------------------------
  // prescaler cleared with the timer so a new divisor starts a whole period
  srbg_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(divisor_written),
    .factor(factor),
    .step(prescale_step)
  );

  // one timer for both modes
  srbg_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .clear(divisor_written),
    .step(prescale_step),
    .wide(wide_reg),
    .divisor(divisor_value),
    .tick(baud_tick)
  );

  // ----------------------------------------
  // receive pin edge detect
  // ----------------------------------------
  // idle line is high; reset to high avoids a false edge at start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= receive_pin;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  logic rx_fall;
  logic wake_event;

  assign rx_fall = rx_prev_reg && !rx_sync_reg;
  assign wake_event = wake_reg && !sync_bit && rx_fall;

  // ----------------------------------------
  // wake-up and receive flag
  // ----------------------------------------
  // setting wins over a clear in the same cycle
  assign rx_flag_next = wake_event ? 1'b1 : (receive_flag_clear ? 1'b0 : rx_flag_reg);

  // software write wins over hardware self-clear
  assign wake_next = wr_baud ? wbyte[BC_WAKE_BIT] : (wake_event ? 1'b0 : wake_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_flag_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      rx_flag_reg <= rx_flag_next;
      wake_reg <= wake_next;
    end
  end

  // ----------------------------------------
  // auto-baud enable
  // ----------------------------------------
  // completion ignored in sync mode since detection never runs there
  assign autobaud_next = wr_baud ? wbyte[BC_AUTOBAUD_BIT] :
                         ((autobaud_done && !sync_bit) ? 1'b0 : autobaud_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autobaud_reg <= 1'b0;
    end else begin
      autobaud_reg <= autobaud_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign autobaud_active = autobaud_reg && !sync_bit;
  assign sync_mode = sync_bit;
  assign high_speed_select = high_speed_bit;
  assign wide_divider_select = wide_reg;
  assign clock_polarity_select = polarity_reg;
  assign wake_on_edge_enable = wake_reg;
  assign receive_interrupt_flag = rx_flag_reg;
  assign transmit_control = transmit_control_view;
  assign receive_control = receive_control_reg;

endmodule : srbg_top

// [src/srbg_pkg.sv]
// Behaviour
// - after reset the timer counts 8 bits using only the low divisor byte
// - wide divider select set makes the timer 16 bits using both bytes
// - one free-running timer serves asynchronous and synchronous operation alike
// - the divisor byte pair sets the period of the free-running timer
// - asynchronous multiplier depends on high speed select and wide divider select
// - synchronous mode ignores the high speed select bit
// - writing either divisor byte clears the timer at once
// - async, 8-bit, normal speed: rate is clock over 64 times divisor plus one
// - async, 16-bit, normal speed: rate is clock over 16 times divisor plus one
// - sync, 8-bit: rate is clock over 4 times divisor plus one
// - divisor is high byte above low byte
// - low register holds bits 7..0, high register bits 15..8
// - baud control: bit4 polarity, bit3 wide, bit1 wake, bit0 autobaud; 5,2 unused
// - transmit control: bit4 synchronous mode, bit2 high speed select
package srbg_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_BAUD_CONTROL = 8'h00;
  localparam logic [7:0] OFF_TRANSMIT_CONTROL = 8'h04;
  localparam logic [7:0] OFF_RECEIVE_CONTROL = 8'h08;
  localparam logic [7:0] OFF_DIVISOR_LOW = 8'h0c;
  localparam logic [7:0] OFF_DIVISOR_HIGH = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BC_AUTOBAUD_OVF_BIT = 7;
  localparam int BC_RX_IDLE_BIT = 6;
  localparam int BC_POLARITY_BIT = 4;
  localparam int BC_WIDE_BIT = 3;
  localparam int BC_WAKE_BIT = 1;
  localparam int BC_AUTOBAUD_BIT = 0;
  localparam int TC_SYNC_BIT = 4;
  localparam int TC_HIGH_SPEED_BIT = 2;
  localparam int TC_SHIFT_EMPTY_BIT = 1;

  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [23:0] UPPER_ZERO = 24'h000000;

  // ----------------------------------------
  // divide factors
  // ----------------------------------------
  localparam int FACTOR_WIDTH = 7;
  localparam logic [6:0] FACTOR_SLOW = 7'h40;
  localparam logic [6:0] FACTOR_MID = 7'h10;
  localparam logic [6:0] FACTOR_FAST = 7'h04;

  // selects the prescale factor from mode bits
  function automatic logic [6:0] srbg_factor(input logic sync, input logic wide, input logic high_speed);
    logic [6:0] f;
    if (sync) begin
      f = FACTOR_FAST;
    end else if (wide) begin
      f = high_speed ? FACTOR_FAST : FACTOR_MID;
    end else begin
      f = high_speed ? FACTOR_MID : FACTOR_SLOW;
    end
    return f;
  endfunction : srbg_factor

endpackage : srbg_pkg

// [src/srbg_prescaler.sv]
module srbg_prescaler
  import srbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic [6:0] factor,
  output logic step
);

  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [6:0] last_value;

  // ----------------------------------------
  // prescale counter
  // ----------------------------------------
  // >= so a factor change mid-count never wraps the long way round
  assign last_value = factor - 7'h01;
  assign step = (cnt_reg >= last_value);
  assign cnt_next = (clear || step) ? 7'h00 : cnt_reg + 7'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : srbg_prescaler

// [src/srbg_timer.sv]
module srbg_timer
  import srbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic step,
  input wire logic wide,
  input wire logic [15:0] divisor,
  output logic tick
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] limit;
  logic at_end;
  logic tick_reg;

  // ----------------------------------------
  // period counter
  // ----------------------------------------
  assign limit = wide ? divisor : {8'h00, divisor[7:0]};
  assign at_end = (count_reg >= limit);
  assign count_next = clear ? 16'h0000 : (step ? (at_end ? 16'h0000 : count_reg + 16'h0001) : count_reg);
  assign tick = tick_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg <= step && at_end && !clear;
    end
  end

endmodule : srbg_timer

// [bench/srbg_asserts.sv]
module srbg_asserts
  import srbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic baud_tick,
  input wire logic [15:0] divisor_value,
  input wire logic sync_mode,
  input wire logic high_speed_select,
  input wire logic wide_divider_select,
  input wire logic wake_on_edge_enable,
  input wire logic autobaud_active,
  input wire logic autobaud_done,
  input wire logic receive_interrupt_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // decode
  // ----
  wire logic wr = psel & penable & pwrite;
  wire logic mapped = paddr inside {OFF_BAUD_CONTROL, OFF_TRANSMIT_CONTROL, OFF_RECEIVE_CONTROL,
    OFF_DIVISOR_LOW, OFF_DIVISOR_HIGH};
  wire logic bc_wr = wr & (paddr == OFF_BAUD_CONTROL);
  sequence div_wr;
    wr && (paddr == OFF_DIVISOR_LOW || paddr == OFF_DIVISOR_HIGH);
  endsequence
  // shortest legal period is 4 cycles
  sequence quiet3;
    !baud_tick [*3];
  endsequence
  a_clear_on_write: assert property (div_wr |=> quiet3) else $error("tick too soon after divisor write");
  a_tick_single: assert property (baud_tick |=> quiet3) else $error("ticks too close");
  a_low_byte: assert property (wr && paddr == OFF_DIVISOR_LOW |=> divisor_value[7:0] == $past(pwdata[7:0]))
    else $error("low divisor byte not stored");
  a_high_byte: assert property (wr && paddr == OFF_DIVISOR_HIGH |=> divisor_value[15:8] == $past(pwdata[7:0]))
    else $error("high divisor byte not stored");
  a_mode_bits: assert property (wr && paddr == OFF_TRANSMIT_CONTROL |=>
    sync_mode == $past(pwdata[4]) && high_speed_select == $past(pwdata[2])) else $error("mode bits wrong");
  a_wide_bit: assert property (bc_wr |=> wide_divider_select == $past(pwdata[3]))
    else $error("wide select wrong");
  a_autobaud_sync: assert property (sync_mode |-> !autobaud_active) else $error("autobaud active in sync");
  a_autobaud_clear: assert property (autobaud_done && !sync_mode && !bc_wr |=> !autobaud_active)
    else $error("autobaud enable not cleared on completion");
  a_wake_flag: assert property ($fell(wake_on_edge_enable) && !$past(bc_wr) |-> receive_interrupt_flag)
    else $error("wake cleared without flag");
  a_bus_error: assert property (psel && penable |-> pslverr == !mapped) else $error("bus error wrong");
endmodule : srbg_asserts

bind srbg_top srbg_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
  .baud_tick, .divisor_value, .sync_mode, .high_speed_select, .wide_divider_select, .wake_on_edge_enable,
  .autobaud_active, .autobaud_done, .receive_interrupt_flag);

// [bench/serial_port_baud_rate_generator_test.sv]
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module serial_port_baud_rate_generator_test
  import srbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] tc; logic [7:0] bc; logic [7:0] lo; logic [7:0] hi; logic [15:0] per;} srbg_row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, receive_pin, receive_idle_flag;
  logic autobaud_overflow_flag, autobaud_done, transmit_shift_empty, receive_flag_clear, baud_tick;
  logic sync_mode, high_speed_select, wide_divider_select, clock_polarity_select, wake_on_edge_enable;
  logic autobaud_active, receive_interrupt_flag, err;
  logic [7:0] paddr, transmit_control, receive_control;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] divisor_value;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  int c;
  // tc, bc, low, high, cycles from clearing write to first tick
  srbg_row_type rows [7] = '{'{8'h00, 8'h00, 8'h02, 8'h05, 16'd192}, '{8'h04, 8'h00, 8'h03, 8'h00, 16'd64},
    '{8'h00, 8'h08, 8'h02, 8'h00, 16'd48}, '{8'h04, 8'h08, 8'h01, 8'h01, 16'd1032},
    '{8'h10, 8'h00, 8'h05, 8'h00, 16'd24}, '{8'h14, 8'h00, 8'h05, 8'h00, 16'd24},
    '{8'h14, 8'h08, 8'h00, 8'h01, 16'd1028}};

  srbg_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .receive_pin, .receive_idle_flag, .autobaud_overflow_flag, .autobaud_done, .transmit_shift_empty,
    .receive_flag_clear, .baud_tick, .divisor_value, .sync_mode, .high_speed_select, .wide_divider_select,
    .clock_polarity_select, .wake_on_edge_enable, .autobaud_active, .receive_interrupt_flag,
    .transmit_control, .receive_control);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // a spare cycle before setup keeps psel from being driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic measure(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (baud_tick !== 1'b1 && n < 3000);
  endtask : measure

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 10000) begin
      n_fail++;
      $display("done timeout");
      give_verdict;
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, receive_idle_flag, autobaud_overflow_flag} = '0;
    {autobaud_done, receive_flag_clear, paddr, pwdata} = '0;
    receive_pin = 1'b1;
    transmit_shift_empty = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b0, 8'h04 * i[7:0], 8'h00);
      `CHK("reset value", (i == 1) ? 8'h02 : 8'h00, rd[7:0])
    end
    apb(1'b0, 8'h14, 8'h00);
    `CHK("unmapped error", 1'b1, err)
    $display("done reset");
    foreach (rows[i]) begin
      apb(1'b1, OFF_TRANSMIT_CONTROL, rows[i].tc);
      apb(1'b1, OFF_BAUD_CONTROL, rows[i].bc);
      apb(1'b1, OFF_DIVISOR_HIGH, rows[i].hi);
      apb(1'b1, OFF_DIVISOR_LOW, rows[i].lo);
      measure(c);
      `CHK("tick period", rows[i].per, c[15:0])
      `CHK("divisor", {rows[i].hi, rows[i].lo}, divisor_value)
    end
    $display("done rates");
    // wide mode is still selected, so the high byte must be cleared first
    apb(1'b1, OFF_DIVISOR_HIGH, 8'h00);
    apb(1'b1, OFF_DIVISOR_LOW, 8'h05);
    repeat (10) @(posedge pclk);
    apb(1'b1, OFF_DIVISOR_LOW, 8'h02);
    measure(c);
    `CHK("restart period", 16'd12, c[15:0])
    apb(1'b1, OFF_RECEIVE_CONTROL, 8'ha5);
    apb(1'b0, OFF_RECEIVE_CONTROL, 8'h00);
    `CHK("receive control", 8'ha5, rd[7:0])
    `CHK("mapped error", 1'b0, err)
    `CHK("receive port", 8'ha5, receive_control)
    `CHK("ready", 1'b1, pready)
    autobaud_overflow_flag <= 1'b1;
    receive_idle_flag <= 1'b1;
    apb(1'b1, OFF_BAUD_CONTROL, 8'hff);
    apb(1'b0, OFF_BAUD_CONTROL, 8'h00);
    `CHK("baud control", 8'hdb, rd[7:0])
    `CHK("polarity", 1'b1, clock_polarity_select)
    `CHK("wide select", 1'b1, wide_divider_select)
    `CHK("transmit control", 8'h16, transmit_control)
    `CHK("sync mode", 1'b1, sync_mode)
    `CHK("high speed", 1'b1, high_speed_select)
    `CHK("autobaud in sync", 1'b0, autobaud_active)
    receive_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    `CHK("flag in sync", 1'b0, receive_interrupt_flag)
    receive_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, OFF_TRANSMIT_CONTROL, 8'h00);
    #1;
    `CHK("autobaud on", 1'b1, autobaud_active)
    @(posedge pclk);
    autobaud_done <= 1'b1;
    @(posedge pclk);
    autobaud_done <= 1'b0;
    @(posedge pclk);
    #1;
    `CHK("autobaud off", 1'b0, autobaud_active)
    receive_pin <= 1'b0;
    c = 0;
    do begin
      @(posedge pclk);
      #1;
      c++;
    end while (receive_interrupt_flag !== 1'b1 && c < 8);
    `CHK("wake flag", 1'b1, receive_interrupt_flag)
    `CHK("wake enable", 1'b0, wake_on_edge_enable)
    receive_flag_clear <= 1'b1;
    @(posedge pclk);
    receive_flag_clear <= 1'b0;
    receive_pin <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK("flag cleared", 1'b0, receive_interrupt_flag)
    $display("done control");
    give_verdict;
  end
endmodule : serial_port_baud_rate_generator_test
